// >>> verilog/stl_defs.svh
// offsets, field layout, reset values and sizes of the lane level bank
// assumes: included by bare name from the package and the design modules
`ifndef STL_DEFS_SVH
`define STL_DEFS_SVH

`define STL_ADDR_W 12
`define STL_LANES 4
`define STL_LANE_IDX_W 2

`define STL_OFF_LEVEL_CTL1 12'h000
`define STL_OFF_XCVR_CTL 12'h004
`define STL_OFF_PORT_STAT 12'h008
`define STL_OFF_APPLIED 12'h00c

`define STL_FIELDS_MSB 31
`define STL_FIELDS_LSB 8
`define STL_LVL3_LSB 8
`define STL_FINE3_LSB 13
`define STL_LVL6_LSB 16
`define STL_FINE6_LSB 21
`define STL_LS1_LSB 24
`define STL_LS2_LSB 28

`define STL_RST_LVL3 5'h17
`define STL_RST_FINE3 3'h4
`define STL_RST_LVL6 5'h13
`define STL_RST_FINE6 3'h2
`define STL_RST_LS1 4'h9
`define STL_RST_LS2 4'h8
`define STL_RST_LANE_CHOICE 4'h1

`endif

// >>> verilog/stl_pkg.sv
// types shared by the lane level bank and its per-lane store
// assumes: stl_defs.svh on the include path
`include "stl_defs.svh"

package stl_pkg;

    // packs exactly onto bits 31:8 of the level control word
    typedef struct packed {
        logic [3:0] drive_level_low_swing_rate2;
        logic [3:0] drive_level_low_swing_rate1;
        logic [2:0] fine_deemph_full_6p0_rate2;
        logic [4:0] drive_level_full_6p0_rate2;
        logic [2:0] fine_deemph_full_3p5_rate2;
        logic [4:0] drive_level_full_3p5_rate2;
    } stl_fields_s;

    typedef struct packed {
        logic rate2;
        logic deemph_select;
        logic low_swing_enable;
    } stl_mode_s;

    typedef struct packed {
        logic own_code;
        logic deemph_on;
        logic [2:0] fine_deemph;
        logic [4:0] drive_level;
    } stl_applied_s;

    typedef stl_applied_s [`STL_LANES-1:0] stl_applied_t;

endpackage

// >>> verilog/stl_lane_store.sv
// per-lane store of the level codes and the code applied to the driver
// assumes: write enable already qualified by lane choice and bus completion
`timescale 1ns/1ps
`default_nettype none
`include "stl_defs.svh"

module stl_lane_store
    import stl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire stl_mode_s mode,
    output stl_fields_s fields,
    output stl_applied_s applied
);

    logic [31:0] byte_mask;
    stl_fields_s fields_nxt;
    stl_applied_s applied_nxt;

    assign byte_mask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                        {8{wstrb[1]}}, {8{wstrb[0]}}};

    always_comb begin
        fields_nxt = stl_fields_s'(
            (fields & ~byte_mask[`STL_FIELDS_MSB:`STL_FIELDS_LSB])
            | (wdata[`STL_FIELDS_MSB:`STL_FIELDS_LSB]
               & byte_mask[`STL_FIELDS_MSB:`STL_FIELDS_LSB]));
    end

    // only reset or a chosen-lane write changes a lane
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fields.drive_level_low_swing_rate2 <= `STL_RST_LS2;
            fields.drive_level_low_swing_rate1 <= `STL_RST_LS1;
            fields.fine_deemph_full_6p0_rate2 <= `STL_RST_FINE6;
            fields.drive_level_full_6p0_rate2 <= `STL_RST_LVL6;
            fields.fine_deemph_full_3p5_rate2 <= `STL_RST_FINE3;
            fields.drive_level_full_3p5_rate2 <= `STL_RST_LVL3;
        end else if (wr_en) begin
            fields <= fields_nxt;
        end
    end

    always_comb begin
        applied_nxt = '0;
        if (mode.low_swing_enable) begin
            // de-emphasis is off in low swing, fine codes unused
            applied_nxt.own_code = 1'b1;
            applied_nxt.deemph_on = 1'b0;
            if (mode.rate2) begin
                applied_nxt.drive_level =
                    {1'b0, fields.drive_level_low_swing_rate2};
            end else begin
                applied_nxt.drive_level =
                    {1'b0, fields.drive_level_low_swing_rate1};
            end
        end else if (mode.rate2) begin
            applied_nxt.own_code = 1'b1;
            applied_nxt.deemph_on = 1'b1;
            if (mode.deemph_select) begin
                applied_nxt.drive_level =
                    fields.drive_level_full_3p5_rate2;
                applied_nxt.fine_deemph =
                    fields.fine_deemph_full_3p5_rate2;
            end else begin
                applied_nxt.drive_level =
                    fields.drive_level_full_6p0_rate2;
                applied_nxt.fine_deemph =
                    fields.fine_deemph_full_6p0_rate2;
            end
        end
        // full swing at rate 1 uses codes held outside this bank
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            applied <= '0;
        end else begin
            applied <= applied_nxt;
        end
    end

endmodule // stl_lane_store
`default_nettype wire

// >>> verilog/stl_lane_level_ctl.sv
// lane transmit level bank: apb slave, lane choice and per-lane stores
// assumes: port mode inputs come from logic on ref_clk, apb on ref_clk
//
// Overview of operation
// - fine -3.5dB code rate 2, 15:13, 0x4
// - fine codes ignored in low swing
// - level -6.0dB code rate 2, 20:16, 0x13
// - fine -6.0dB code rate 2, 23:21, 0x2
// - low swing rate 1 level, 27:24, 0x9
// - low swing rate 2 level, 31:28, 0x8
// - de-emphasis select picks -3.5 or -6.0 codes
// - writes reach only lanes in lane choice
// - stored values kept for unchosen lanes too
// - level -3.5dB code rate 2, 12:8, 0x17
`timescale 1ns/1ps
`default_nettype none
`include "stl_defs.svh"

module stl_lane_level_ctl
    import stl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`STL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rate2,
    input wire logic deemph_select,
    input wire logic low_swing_enable,
    output stl_applied_t lane_applied
);

    logic [3:0] lane_choice_r;
    logic [`STL_LANES-1:0] lane_wr;
    logic xfer_done;
    logic access_wait;
    logic wr_level;
    logic wr_xcvr;
    logic addr_hit;
    logic [31:0] rdata_nxt;
    logic sel_any;
    logic [`STL_LANE_IDX_W-1:0] sel_idx;
    stl_mode_s mode;
    stl_fields_s lane_fields [`STL_LANES];
    stl_applied_t applied_int;

    assign mode.rate2 = rate2;
    assign mode.deemph_select = deemph_select;
    assign mode.low_swing_enable = low_swing_enable;

    // one wait state: pready rises in the second access cycle
    assign access_wait = psel && penable && !pready;
    assign xfer_done = psel && penable && pready;
    assign wr_level = xfer_done && pwrite && addr_hit
                      && (paddr == `STL_OFF_LEVEL_CTL1);
    assign wr_xcvr = xfer_done && pwrite
                     && (paddr == `STL_OFF_XCVR_CTL);

    always_comb begin
        unique case (paddr)
            `STL_OFF_LEVEL_CTL1,
            `STL_OFF_XCVR_CTL,
            `STL_OFF_PORT_STAT,
            `STL_OFF_APPLIED: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // lowest chosen lane answers reads
    always_comb begin
        sel_any = 1'b0;
        sel_idx = '0;
        for (int i = `STL_LANES - 1; i >= 0; i--) begin
            if (lane_choice_r[i]) begin
                sel_any = 1'b1;
                sel_idx = `STL_LANE_IDX_W'(i);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lane_choice_r <= `STL_RST_LANE_CHOICE;
        end else if (wr_xcvr && pstrb[0]) begin
            lane_choice_r <= pwdata[3:0];
        end
    end

    generate
        for (genvar g = 0; g < `STL_LANES; g++) begin : g_lane
            // unchosen lanes keep their codes untouched
            assign lane_wr[g] = wr_level && lane_choice_r[g];
            stl_lane_store u_store (
                .ref_clk(ref_clk),
                .rst(rst),
                .wr_en(lane_wr[g]),
                .wdata(pwdata),
                .wstrb(pstrb),
                .mode(mode),
                .fields(lane_fields[g]),
                .applied(applied_int[g])
            );
        end
    endgenerate

    assign lane_applied = applied_int;

    always_comb begin
        rdata_nxt = '0;
        unique case (paddr)
            `STL_OFF_LEVEL_CTL1: begin
                // no chosen lane reads as zero
                if (sel_any) begin
                    rdata_nxt[`STL_FIELDS_MSB:`STL_FIELDS_LSB] =
                        lane_fields[sel_idx];
                end
            end
            `STL_OFF_XCVR_CTL: begin
                rdata_nxt[3:0] = lane_choice_r;
            end
            `STL_OFF_PORT_STAT: begin
                rdata_nxt[2:0] = mode;
            end
            `STL_OFF_APPLIED: begin
                if (sel_any) begin
                    rdata_nxt[9:0] = applied_int[sel_idx];
                end
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= access_wait;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
        end else if (access_wait && !pwrite) begin
            prdata <= rdata_nxt;
        end else if (xfer_done) begin
            prdata <= '0;
        end
    end

    // unmapped addresses answer with an error, writes dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (access_wait) begin
            pslverr <= !addr_hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule // stl_lane_level_ctl
`default_nettype wire

// >>> verification/stl_lane_level_ctl_sva.sv
// checker of the lane level bank: apb timing and applied codes
// assumes: bound to stl_lane_level_ctl, one clock, rst active high
`timescale 1ns/1ps
`default_nettype none
`include "stl_defs.svh"

module stl_lane_level_ctl_sva
    import stl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rate2,
    input wire logic low_swing_enable,
    input wire stl_applied_t lane_applied
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_wait_state;
        psel && !penable |-> !pready [*2] ##1 pready;
    endproperty
    a_wait_state: assert property (p_wait_state)
        else $error("pready not on second access cycle");
    property p_ready_pulse;
        pready |=> !pready && prdata == 32'h0;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready or read data held too long");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside answer");
    property p_err_ready;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without answer");
    property p_low_fine;
        low_swing_enable |=> !lane_applied[0].deemph_on &&
            lane_applied[0].fine_deemph == 3'h0;
    endproperty
    a_low_fine: assert property (p_low_fine)
        else $error("fine code applied in low swing");
    property p_low_own;
        low_swing_enable |=> lane_applied[3].own_code &&
            !lane_applied[3].drive_level[4];
    endproperty
    a_low_own: assert property (p_low_own)
        else $error("low swing level not applied");
    property p_full2;
        rate2 && !low_swing_enable |=> lane_applied[1].own_code &&
            lane_applied[1].deemph_on;
    endproperty
    a_full2: assert property (p_full2)
        else $error("full swing rate 2 code missing");
    property p_rate1_off;
        !rate2 && !low_swing_enable |=> lane_applied[2] == '0;
    endproperty
    a_rate1_off: assert property (p_rate1_off)
        else $error("bank code applied at rate 1 full swing");

    c_err: cover property (pslverr);
    c_read: cover property (pready && prdata != 32'h0);
    c_low2: cover property (low_swing_enable && rate2);
endmodule // stl_lane_level_ctl_sva

bind stl_lane_level_ctl stl_lane_level_ctl_sva u_sva (.ref_clk, .rst,
    .psel, .penable, .prdata, .pready, .pslverr, .rate2,
    .low_swing_enable, .lane_applied);
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the lane level bank against a lane model
// assumes: design and checker compiled before, 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "stl_defs.svh"
`define CHK(a, e) begin \
    n_compared++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("ERROR t=%0t got %h exp %h", $time, a, e); \
    end \
end

module tb_top
    import stl_pkg::*;
;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic rate2, deemph_select, low_swing_enable;
    logic [`STL_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [3:0] pstrb, choice, s;
    logic [31:0] mdl [4];
    stl_applied_t lane_applied;
    int mismatches, n_compared;

    stl_lane_level_ctl uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rate2(rate2), .deemph_select(deemph_select),
        .low_swing_enable(low_swing_enable), .lane_applied(lane_applied));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // low swing ignores fine codes, rate 1 full swing is outside this bank
    function automatic logic [9:0] exp_app(input logic [31:0] w);
        if (low_swing_enable) return {6'h20, rate2 ? w[31:28] : w[27:24]};
        if (!rate2) return 10'h0;
        return deemph_select ? {2'h3, w[15:8]} : {2'h3, w[23:16]};
    endfunction

    function automatic logic [31:0] exp_rd();
        for (int l = 0; l < 4; l++) if (choice[l]) return mdl[l];
        return 32'h0;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] dd, input logic [3:0] ss);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        pstrb <= ss;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 9);
        rd = prdata;
        er = pslverr;
        if (k >= 9) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic set_choice(input logic [3:0] c);
        apb(1'b1, `STL_OFF_XCVR_CTL, {28'h0, c}, 4'hf);
        choice = c;
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(4000 * 50);
        mismatches++;
        test_done;
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        rst = 1'b1;
        {rate2, deemph_select, low_swing_enable} = 3'h0;
        choice = 4'h1;
        mismatches = 0;
        n_compared = 0;
        for (int l = 0; l < 4; l++) mdl[l] = 32'h89539700;
        void'($urandom(32'h1db6));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, `STL_OFF_LEVEL_CTL1, 0, 0);
        `CHK(rd, 32'h89539700)
        apb(1'b0, `STL_OFF_XCVR_CTL, 0, 0);
        `CHK(rd, 32'h1)
        for (int i = 0; i < 16; i++) begin
            {rate2, deemph_select, low_swing_enable} <= i[2:0];
            set_choice(4'($urandom));
            d = $urandom;
            s = 4'($urandom);
            apb(1'b1, `STL_OFF_LEVEL_CTL1, d, s);
            `CHK(er, 1'b0)
            // each byte follows its own strobe, byte 0 holds no field
            for (int l = 0; l < 4; l++)
                for (int b = 1; b < 4; b++)
                    if (choice[l] && s[b]) mdl[l][8*b+:8] = d[8*b+:8];
            apb(1'b0, `STL_OFF_LEVEL_CTL1, 0, 0);
            `CHK(rd, exp_rd())
            for (int l = 0; l < 4; l++) begin
                set_choice(4'(1 << l));
                apb(1'b0, `STL_OFF_LEVEL_CTL1, 0, 0);
                `CHK(rd, mdl[l])
                `CHK(lane_applied[l], exp_app(mdl[l]))
            end
            apb(1'b0, `STL_OFF_APPLIED, 0, 0);
            `CHK(rd, {22'h0, exp_app(mdl[3])})
            apb(1'b0, `STL_OFF_PORT_STAT, 0, 0);
            `CHK(rd, {29'h0, i[2:0]})
        end
        apb(1'b1, 12'h010, 32'hffffffff, 4'hf);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h010, 0, 0);
        `CHK({er, rd}, {1'b1, 32'h0})
        // reset in mid-run, mode idle so no applied code is pending
        rst <= 1'b1;
        {rate2, deemph_select, low_swing_enable} <= 3'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, `STL_OFF_XCVR_CTL, 0, 0);
        `CHK(rd, 32'h1)
        for (int l = 0; l < 4; l++) begin
            set_choice(4'(1 << l));
            apb(1'b0, `STL_OFF_LEVEL_CTL1, 0, 0);
            `CHK(rd, 32'h89539700)
            `CHK(lane_applied[l], 10'h0)
        end
        test_done;
    end
endmodule // tb_top
`default_nettype wire
